// ### hw/mdi_pkg.sv
// constants, field layouts and state codes for the management serial slave
// assumes a 125 MHz system clock and a station manager clocking at 24 MHz at most
package mdi_pkg;

   // ----------------------------------------------------------------
   // clocking
   // ----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned MDC_MAX_HZ = 24_000_000;
   // shortest management clock period in system cycles, rounded up
   localparam int unsigned MDC_MIN_CYC = (CLK_HZ + MDC_MAX_HZ - 1) / MDC_MAX_HZ;
   // cycles after reset release before the straps are taken
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // ----------------------------------------------------------------
   // frame layout
   // ----------------------------------------------------------------
   localparam int unsigned STRAP_W = 4;
   localparam int unsigned FIELD_W = 5;
   localparam int unsigned DATA_W = 16;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [4:0] LAST_FIELD_BIT = 5'h04;
   localparam logic [4:0] LAST_DATA_BIT = 5'h0F;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [4:0] REG_MMD_ACCESS_CONTROL = 5'h0D;
   localparam logic [4:0] REG_MMD_ADDRESS_OR_DATA = 5'h0E;
   localparam int unsigned CTRL_DEVSEL_LSB = 0;
   localparam int unsigned CTRL_FN_LSB = 14;
   localparam logic [4:0] DEVSEL_ALL_ONES = 5'h1F;
   localparam logic [1:0] FN_ADDRESS = 2'h0;
   localparam logic [1:0] FN_DATA = 2'h1;
   localparam logic [1:0] FN_DATA_INC_RW = 2'h2;
   localparam logic [1:0] FN_DATA_INC_WR = 2'h3;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] POINTER_RESET = 16'h0000;
   localparam logic [15:0] DIRECT_RESET = 16'h0000;
   localparam logic [15:0] DIRECT_LIMIT = 16'h0020;
   localparam logic [15:0] EXT_BASE = 16'h0020;
   localparam int unsigned EXT_DEPTH = 64;
   localparam logic [15:0] EXT_LIMIT = 16'h0060;

   // ----------------------------------------------------------------
   // frame receiver states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_OP = 3'b010,
      ST_PHYAD = 3'b011,
      ST_REGAD = 3'b100,
      ST_TA = 3'b101,
      ST_DATA = 3'b110
   } mdi_state_t;

endpackage : mdi_pkg

// ### hw/mdi_regs.sv
// register space behind the serial slave: 32 direct words, the indirect
// control and address/data pair, and a small extended window
// assumes rd_en and wr_en are single-cycle pulses, never together
`timescale 1ns/1ps

module mdi_regs (
   input wire logic clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic rd_en, // pulse: read frame fetched rd_addr
   input wire logic [4:0] rd_addr, // direct register address of the read
   output logic [15:0] rd_data, // read value, valid with rd_en
   input wire logic wr_en, // pulse: write frame completed
   input wire logic [4:0] wr_addr, // direct register address of the write
   input wire logic [15:0] wr_data // written value
);

   typedef struct packed {
      logic [15:0] ctrl;
      logic [15:0] ptr;
   } mdi_regs_state_t;

   mdi_regs_state_t q;
   mdi_regs_state_t next_q;
   logic [15:0] direct [0:31];
   logic [15:0] ext [0:mdi_pkg::EXT_DEPTH-1];
   logic devsel_ok;
   logic [1:0] fn;
   logic ind_wr;

   // ----------------------------------------------------------------
   // indirect target decode
   // ----------------------------------------------------------------
   function automatic logic is_direct_ok(input logic [15:0] p);
      // the indirect pair itself is never an indirect target
      is_direct_ok = (p < mdi_pkg::DIRECT_LIMIT) &&
                     (p[4:0] != mdi_pkg::REG_MMD_ACCESS_CONTROL) &&
                     (p[4:0] != mdi_pkg::REG_MMD_ADDRESS_OR_DATA);
   endfunction : is_direct_ok

   function automatic logic is_ext(input logic [15:0] p);
      is_ext = (p >= mdi_pkg::EXT_BASE) && (p < mdi_pkg::EXT_LIMIT);
   endfunction : is_ext

   function automatic logic [5:0] ext_idx(input logic [15:0] p);
      logic [15:0] off;
      off = p - mdi_pkg::EXT_BASE;
      ext_idx = off[5:0];
   endfunction : ext_idx

   assign devsel_ok = q.ctrl[mdi_pkg::CTRL_DEVSEL_LSB +: 5] == mdi_pkg::DEVSEL_ALL_ONES;
   assign fn = q.ctrl[mdi_pkg::CTRL_FN_LSB +: 2];
   assign ind_wr = wr_en && (wr_addr == mdi_pkg::REG_MMD_ADDRESS_OR_DATA) && devsel_ok &&
                   (fn != mdi_pkg::FN_ADDRESS);

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb
   begin
      rd_data = direct[rd_addr];
      if (rd_addr == mdi_pkg::REG_MMD_ACCESS_CONTROL)
         rd_data = q.ctrl;
      else if (rd_addr == mdi_pkg::REG_MMD_ADDRESS_OR_DATA)
      begin
         if (!devsel_ok)
            rd_data = 16'h0000;
         else if (fn == mdi_pkg::FN_ADDRESS)
            rd_data = q.ptr;
         else if (is_direct_ok(q.ptr))
            rd_data = direct[q.ptr[4:0]];
         else if (is_ext(q.ptr))
            rd_data = ext[ext_idx(q.ptr)];
         else
            rd_data = 16'h0000;
      end
   end

   // control and pointer update; pointer moves only for the right select
   always_comb
   begin
      next_q = q;
      if (wr_en && wr_addr == mdi_pkg::REG_MMD_ACCESS_CONTROL)
         next_q.ctrl = wr_data;
      if (wr_en && wr_addr == mdi_pkg::REG_MMD_ADDRESS_OR_DATA && devsel_ok)
      begin
         if (fn == mdi_pkg::FN_ADDRESS)
            next_q.ptr = wr_data;
         else if (fn != mdi_pkg::FN_DATA)
            next_q.ptr = q.ptr + 16'h0001;
      end
      if (rd_en && rd_addr == mdi_pkg::REG_MMD_ADDRESS_OR_DATA && devsel_ok &&
          fn == mdi_pkg::FN_DATA_INC_RW)
         next_q.ptr = q.ptr + 16'h0001;
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q.ctrl <= mdi_pkg::CTRL_RESET;
         q.ptr <= mdi_pkg::POINTER_RESET;
      end
      else
         q <= next_q;
   end

   // direct words clear on reset so a first read returns a known zero
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         for (int i = 0; i < 32; i++)
            direct[i] <= mdi_pkg::DIRECT_RESET;
      end
      else if (wr_en && wr_addr != mdi_pkg::REG_MMD_ACCESS_CONTROL &&
          wr_addr != mdi_pkg::REG_MMD_ADDRESS_OR_DATA)
         direct[wr_addr] <= wr_data;
      else if (ind_wr && is_direct_ok(q.ptr))
         direct[q.ptr[4:0]] <= wr_data;
   end

   // the extended window has no reset, as a RAM would not
   always_ff @(posedge clk)
   begin
      if (ind_wr && is_ext(q.ptr))
         ext[ext_idx(q.ptr)] <= wr_data;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_ptr_inc_read: assert property (
      rd_en && rd_addr == mdi_pkg::REG_MMD_ADDRESS_OR_DATA && devsel_ok &&
      fn == mdi_pkg::FN_DATA_INC_RW |=> q.ptr == $past(q.ptr) + 16'h0001)
      else $error("pointer did not step after read");
   chk_ptr_hold_read: assert property (
      rd_en && fn == mdi_pkg::FN_DATA_INC_WR && !wr_en |=> $stable(q.ptr))
      else $error("pointer moved on read in write-increment mode");
   chk_devsel_ignore: assert property (
      wr_en && wr_addr == mdi_pkg::REG_MMD_ADDRESS_OR_DATA && !devsel_ok |=> $stable(q.ptr))
      else $error("pointer changed under wrong select");
   chk_ptr_no_inc: assert property (
      ind_wr && fn == mdi_pkg::FN_DATA |=> $stable(q.ptr))
      else $error("pointer moved in plain data mode");
   cov_ptr_step: cover property (ind_wr && fn == mdi_pkg::FN_DATA_INC_WR);

endmodule : mdi_regs

// ### hw/mdi_slave.sv
// serial management slave: frame receiver, read shifter and register space
// assumes mdc and mdio arrive asynchronously and the pad merges mdio_out/oe
// Summary of operation
// - each data bit is taken on a rising edge of the management clock
// - answer only frames carrying our strapped 4-bit address, captured after reset
// - register field directly picks one of 32 sixteen-bit registers
// - frames open with a zero then a one
// - read: release first turnaround bit, drive zero, then sixteen data bits
// - registers 0 to 31 reachable directly; all but 13 and 14 also through the indirect path
// - indirect access to the control or address/data register is ignored
// - control bits 4:0 hold the managed device select
// - only select all-ones is served; other selects are ignored
// - function 00: address/data register reads or writes the pointer
// - function 01: reach the pointed register, pointer unchanged
// - function 10: reach the pointed register, pointer steps on reads and writes
// - function 11: reach the pointed register, pointer steps on writes only
// - write 0x001F to control, then the address to address/data
// - after 0x001F in control, address/data reads return the pointer
`timescale 1ns/1ps

module mdi_slave (
   input wire logic clk, // 125 MHz system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic mdc, // management clock from the station manager
   input wire logic mdio_in, // management data pin level
   output logic mdio_out, // management data driven value
   output logic mdio_oe, // high while we drive the data pin
   input wire logic [3:0] phy_address_straps, // address strap pins
   output logic [3:0] phy_address, // captured bus address
   output logic frame_busy // high while a frame is being received
);

   typedef struct packed {
      mdi_pkg::mdi_state_t state;
      logic [4:0] cnt;
      logic [15:0] shift;
      logic [1:0] op;
      logic match;
      logic [4:0] reg_addr;
      logic out;
      logic oe;
      logic [1:0] settle;
      logic [3:0] addr;
      logic addr_ok;
      logic mdc_prev;
   } mdi_slave_state_t;

   mdi_slave_state_t q;
   mdi_slave_state_t next_q;
   logic [5:0] pins_s;
   logic mdc_s;
   logic mdio_s;
   logic [3:0] straps_s;
   logic rise;
   logic reading;
   logic [4:0] field;
   logic [1:0] opcode;
   logic rd_en;
   logic wr_en;
   logic [15:0] rd_data;
   logic [15:0] wr_data;

   // ----------------------------------------------------------------
   // pin synchronisers and register space
   // ----------------------------------------------------------------
   mdi_sync #(
      .WIDTH(6)
   ) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .din({phy_address_straps, mdio_in, mdc}),
      .dout(pins_s)
   );

   assign mdc_s = pins_s[0];
   assign mdio_s = pins_s[1];
   assign straps_s = pins_s[5:2];

   mdi_regs u_regs (
      .clk(clk),
      .arst_n(arst_n),
      .rd_en(rd_en),
      .rd_addr(field),
      .rd_data(rd_data),
      .wr_en(wr_en),
      .wr_addr(q.reg_addr),
      .wr_data(wr_data)
   );

   // edge finder works only on the synchronised level, so a stopped
   // clock simply means no edges and the receiver waits where it is
   assign rise = mdc_s && !q.mdc_prev;
   assign reading = q.match && (q.op == mdi_pkg::OP_READ);
   assign field = {q.shift[3:0], mdio_s};
   assign opcode = {q.op[0], mdio_s};
   assign wr_data = {q.shift[14:0], mdio_s};

   // ----------------------------------------------------------------
   // frame receiver
   // ----------------------------------------------------------------
   always_comb
   begin
      next_q = q;
      rd_en = 1'b0;
      wr_en = 1'b0;
      next_q.mdc_prev = mdc_s;
      // straps are taken a few cycles after release; frames wait for it
      if (!q.addr_ok)
      begin
         if (q.settle == mdi_pkg::STRAP_SETTLE)
         begin
            next_q.addr = straps_s;
            next_q.addr_ok = 1'b1;
         end
         else
            next_q.settle = q.settle + 2'h1;
      end
      else if (rise)
      begin
         unique case (q.state)
            mdi_pkg::ST_IDLE:
            begin
               // the pulled-up line reads one; the first zero opens a frame
               if (!mdio_s)
                  next_q.state = mdi_pkg::ST_START;
            end
            mdi_pkg::ST_START:
            begin
               next_q.cnt = 5'h00;
               next_q.state = mdio_s ? mdi_pkg::ST_OP : mdi_pkg::ST_IDLE;
            end
            mdi_pkg::ST_OP:
            begin
               next_q.op = opcode;
               next_q.cnt = q.cnt + 5'h01;
               if (q.cnt != 5'h00)
               begin
                  next_q.cnt = 5'h00;
                  if (opcode == mdi_pkg::OP_READ || opcode == mdi_pkg::OP_WRITE)
                     next_q.state = mdi_pkg::ST_PHYAD;
                  else
                     next_q.state = mdi_pkg::ST_IDLE;
               end
            end
            mdi_pkg::ST_PHYAD:
            begin
               next_q.shift = {q.shift[14:0], mdio_s};
               next_q.cnt = q.cnt + 5'h01;
               if (q.cnt == mdi_pkg::LAST_FIELD_BIT)
               begin
                  next_q.cnt = 5'h00;
                  next_q.match = (field == {1'b0, q.addr});
                  next_q.state = mdi_pkg::ST_REGAD;
               end
            end
            mdi_pkg::ST_REGAD:
            begin
               next_q.shift = {q.shift[14:0], mdio_s};
               next_q.cnt = q.cnt + 5'h01;
               if (q.cnt == mdi_pkg::LAST_FIELD_BIT)
               begin
                  next_q.cnt = 5'h00;
                  next_q.reg_addr = field;
                  next_q.state = mdi_pkg::ST_TA;
                  if (reading)
                  begin
                     rd_en = 1'b1;
                     next_q.shift = rd_data;
                  end
               end
            end
            mdi_pkg::ST_TA:
            begin
               // first turnaround bit stays released on both frame kinds;
               // a write's turnaround bits are the manager's and are not checked
               if (q.cnt == 5'h00)
               begin
                  next_q.cnt = 5'h01;
                  if (reading)
                  begin
                     next_q.oe = 1'b1;
                     next_q.out = 1'b0;
                  end
               end
               else
               begin
                  next_q.cnt = 5'h00;
                  next_q.state = mdi_pkg::ST_DATA;
                  if (reading)
                  begin
                     next_q.out = q.shift[15];
                     next_q.shift = {q.shift[14:0], 1'b0};
                  end
               end
            end
            mdi_pkg::ST_DATA:
            begin
               next_q.cnt = q.cnt + 5'h01;
               if (reading)
               begin
                  next_q.out = q.shift[15];
                  next_q.shift = {q.shift[14:0], 1'b0};
               end
               else
                  next_q.shift = wr_data;
               if (q.cnt == mdi_pkg::LAST_DATA_BIT)
               begin
                  // release the line once the manager has taken the last bit
                  next_q.oe = 1'b0;
                  next_q.out = 1'b0;
                  next_q.cnt = 5'h00;
                  next_q.state = mdi_pkg::ST_IDLE;
                  wr_en = q.match && (q.op == mdi_pkg::OP_WRITE);
               end
            end
            default:
               next_q.state = mdi_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         q.state <= mdi_pkg::ST_IDLE;
         q.cnt <= 5'h00;
         q.shift <= 16'h0000;
         q.op <= 2'h0;
         q.match <= 1'b0;
         q.reg_addr <= 5'h00;
         q.out <= 1'b0;
         q.oe <= 1'b0;
         q.settle <= 2'h0;
         q.addr <= 4'h0;
         q.addr_ok <= 1'b0;
         q.mdc_prev <= 1'b0;
      end
      else
         q <= next_q;
   end

   // outputs straight from flip-flops, except frame_busy, which is decoded from the state
   assign mdio_out = q.out;
   assign mdio_oe = q.oe;
   assign phy_address = q.addr;
   assign frame_busy = q.state != mdi_pkg::ST_IDLE;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   chk_ta_first_release: assert property (
      q.state == mdi_pkg::ST_TA && q.cnt == 5'h00 |-> !mdio_oe)
      else $error("line driven during first turnaround bit");
   chk_ta_second_zero: assert property (
      $rose(mdio_oe) |-> q.state == mdi_pkg::ST_TA && q.cnt == 5'h01 && !mdio_out)
      else $error("second turnaround bit not a driven zero");
   chk_drive_only_match: assert property (
      mdio_oe |-> q.match && q.op == mdi_pkg::OP_READ)
      else $error("line driven outside a matched read");
   chk_release_after_data: assert property (
      $fell(mdio_oe) |-> $past(q.state) == mdi_pkg::ST_DATA &&
      $past(q.cnt) == mdi_pkg::LAST_DATA_BIT)
      else $error("line released at the wrong bit");
   chk_write_pulse_time: assert property (
      wr_en |-> q.state == mdi_pkg::ST_DATA && q.cnt == mdi_pkg::LAST_DATA_BIT &&
      q.op == mdi_pkg::OP_WRITE && q.match)
      else $error("register write outside a matched write frame");
   chk_start_pattern: assert property (
      rise && q.addr_ok && q.state == mdi_pkg::ST_START && !mdio_s |=>
      q.state == mdi_pkg::ST_IDLE)
      else $error("bad start pattern accepted");
   chk_bad_opcode: assert property (
      rise && q.addr_ok && q.state == mdi_pkg::ST_OP && q.cnt == 5'h01 &&
      opcode != mdi_pkg::OP_READ && opcode != mdi_pkg::OP_WRITE |=>
      q.state == mdi_pkg::ST_IDLE)
      else $error("unknown opcode not dropped");
   chk_step_on_rise: assert property (
      q.state != $past(q.state) |-> $past(rise))
      else $error("receiver moved without a clock edge");
   chk_addr_held: assert property (
      q.addr_ok |=> q.addr_ok && $stable(q.addr))
      else $error("captured address changed");
   chk_drive_span: assert property (
      $rose(mdio_oe) |-> mdio_oe [*8])
      else $error("read drive window too short");

   cov_read_frame: cover property ($fell(mdio_oe));
   cov_write_frame: cover property (wr_en);
   cov_foreign_addr: cover property (rise && q.state == mdi_pkg::ST_REGAD && !q.match);

endmodule : mdi_slave

// ### hw/mdi_sync.sv
// two-stage synchroniser for a bundle of slow pins
// assumes each bit is an independent level; no bus coherence is promised
`timescale 1ns/1ps

module mdi_sync #(
   parameter int unsigned WIDTH = 1
) (
   input wire logic clk, // system clock
   input wire logic arst_n, // asynchronous reset, active low
   input wire logic [WIDTH-1:0] din, // asynchronous pins
   output logic [WIDTH-1:0] dout // synchronised levels
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta <= '0;
         dout <= '0;
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : mdi_sync

// ### testbench/mdi_slave_tb_top.sv
// self-checking bench for the management serial slave
// assumes the model in mdi_sta_model.sv and a pull-up on the data pin
`timescale 1ns/1ps

module mdi_slave_tb_top;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [3:0] phy_address_straps = 4'hA;
   logic mdc, sta_oe, sta_val, mdio_out, mdio_oe, frame_busy;
   logic [3:0] phy_address;
   logic [17:0] got;
   int err_total = 0;
   int checks = 0;
   // pull-up wins when nobody drives
   wire mdio_pin = mdio_oe ? mdio_out : (sta_oe ? sta_val : 1'b1);

   // ------------------------------------------------------------
   // structure
   // ------------------------------------------------------------
   always #4 clk = ~clk;

   mdi_slave dut_u (.clk(clk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_pin),
      .mdio_out(mdio_out), .mdio_oe(mdio_oe), .phy_address_straps(phy_address_straps),
      .phy_address(phy_address), .frame_busy(frame_busy));

   mdi_sta_model sta_u (.mdc(mdc), .sta_oe(sta_oe), .sta_val(sta_val), .mdio_pin(mdio_pin));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic end_sim;
      $display("checks %0d err_total %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim

   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      sta_u.xfer(2'h1, {1'b0, phy_address_straps}, ra, d, got);
   endtask : wr

   // busy is looked at mid-frame and again once the frame has ended
   task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
      fork
         sta_u.xfer(2'h2, {1'b0, phy_address_straps}, ra, 16'hFFFF, got);
         begin
            #2000;
            check({15'h0, frame_busy}, 16'h0001);
         end
      join
      check({15'h0, frame_busy}, 16'h0000);
      check({14'h0, got[17:16]}, 16'h0002);
      check(got[15:0], exp);
   endtask : rdc

   // load the pointer, then choose the access function
   task automatic setp(input logic [15:0] ptr, input logic [15:0] ctrl);
      wr(5'h0D, 16'h001F);
      wr(5'h0E, ptr);
      wr(5'h0D, ctrl);
   endtask : setp

   // a driving slave during a manager-driven bit means contention
   always @(posedge clk)
      if (arst_n && sta_oe && mdio_oe !== 1'b0)
         check(16'h0001, 16'h0000);

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_direct;
      check({12'h0, phy_address}, {12'h0, phy_address_straps});
      rdc(5'h00, 16'h0000);
      wr(5'h05, 16'hA5C3);
      wr(5'h1F, 16'h5A3C);
      rdc(5'h05, 16'hA5C3);
      rdc(5'h1F, 16'h5A3C);
      sta_u.xfer(2'h1, {1'b1, phy_address_straps}, 5'h05, 16'h0000, got);
      sta_u.xfer(2'h2, {1'b0, ~phy_address_straps}, 5'h05, 16'h0000, got);
      check(got[15:0], 16'hFFFF);
      rdc(5'h05, 16'hA5C3);
   endtask : t_direct

   task automatic t_pointer;
      setp(16'h0025, 16'h001F);
      rdc(5'h0E, 16'h0025);
      wr(5'h0E, 16'h0020);
      rdc(5'h0E, 16'h0020);
      rdc(5'h0D, 16'h001F);
   endtask : t_pointer

   task automatic t_funcs;
      setp(16'h0020, 16'h401F);
      wr(5'h0E, 16'h1111);
      rdc(5'h0E, 16'h1111);
      wr(5'h0D, 16'h001F);
      rdc(5'h0E, 16'h0020);
      setp(16'h0020, 16'h801F);
      wr(5'h0E, 16'hAAAA);
      wr(5'h0E, 16'hBBBB);
      setp(16'h0020, 16'h801F);
      rdc(5'h0E, 16'hAAAA);
      rdc(5'h0E, 16'hBBBB);
      wr(5'h0D, 16'h001F);
      rdc(5'h0E, 16'h0022);
      setp(16'h0020, 16'hC01F);
      rdc(5'h0E, 16'hAAAA);
      rdc(5'h0E, 16'hAAAA);
      wr(5'h0E, 16'hCCCC);
      rdc(5'h0E, 16'hBBBB);
      wr(5'h0D, 16'h001F);
      rdc(5'h0E, 16'h0021);
   endtask : t_funcs

   task automatic t_direct_via;
      setp(16'h0005, 16'h401F);
      rdc(5'h0E, 16'hA5C3);
      wr(5'h0E, 16'h1234);
      rdc(5'h05, 16'h1234);
      setp(16'h000D, 16'h401F);
      wr(5'h0E, 16'hFFFF);
      rdc(5'h0D, 16'h401F);
      rdc(5'h0E, 16'h0000);
   endtask : t_direct_via

   task automatic t_devsel;
      setp(16'h0030, 16'h001E);
      wr(5'h0E, 16'h0040);
      rdc(5'h0E, 16'h0000);
      rdc(5'h0D, 16'h001E);
      wr(5'h0D, 16'h001F);
      rdc(5'h0E, 16'h0030);
   endtask : t_devsel

   // ------------------------------------------------------------
   // sequence and watchdog
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge clk);
      #1 arst_n = 1'b1;
      repeat (40) @(posedge clk);
      #1;
      t_direct;
      t_pointer;
      t_funcs;
      t_direct_via;
      t_devsel;
      end_sim;
   end

   // about 63 frames of 5.44 us each, some 345 us; 600 us means a hang
   initial
   begin
      #600000;
      err_total++;
      $display("Error at %0t: watchdog expired", $time);
      end_sim;
   end
endmodule : mdi_slave_tb_top

// ### testbench/mdi_sta_model.sv
// station manager model: sends whole frames on a clock that stops between them
// assumes the bench resolves the data pin from both drivers and a pull-up
`timescale 1ns/1ps

module mdi_sta_model (
   output logic mdc, // management clock, low while idle
   output logic sta_oe, // high while the manager drives the pin
   output logic sta_val, // value the manager drives
   input wire logic mdio_pin // resolved pin level
);
   // ------------------------------------------------------------
   // frame engine
   // ------------------------------------------------------------
   // clock parked low so the slave never sees a free-running clock
   initial
   begin
      mdc = 1'b0;
      sta_oe = 1'b0;
      sta_val = 1'b1;
   end

   // two idle ones, start, op, phy, reg, turnaround, data; 160 ns bits
   task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
      input logic [15:0] wd, output logic [17:0] got);
      logic [33:0] bits;
      bits = {4'hD, op, phy, ra, 2'h2, wd};
      got = 18'h0;
      for (int i = 33; i >= 0; i--)
      begin
         sta_oe = !((op == 2'h2) && (i < 18));
         sta_val = bits[i];
         #80 mdc = 1'b1;
         if (i < 18)
            got[i] = mdio_pin;
         #80 mdc = 1'b0;
      end
      sta_oe = 1'b0;
   endtask : xfer
endmodule : mdi_sta_model
